// [bench/imru_host.sv]
// ----------------------------------------------------------------
// Host side bus master
// ----------------------------------------------------------------
module imru_host (
	input  wire logic        clk,     // Bus clock
	output logic             psel,    // Select
	output logic             penable, // Access phase
	output logic             pwrite,  // Direction
	output logic [7:0]       paddr,   // Byte address
	output logic [31:0]      pwdata,  // Write data
	input  wire logic [31:0] prdata,  // Read data
	input  wire logic        pready,  // Answer
	input  wire logic        pslverr  // Error flag
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
	end

	// Entered just after a rising edge; one idle cycle follows
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
endmodule

// [bench/imru_tb.sv]
module imru_tb;
	import imru_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic [31:0] rdExp;
		logic        errExp;
	} imru_row_s;

	logic        clk;
	logic        rst_n;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [7:0]  timerIrq;
	logic [11:0] extIrq;
	logic [3:0]  auxIrq;
	logic [11:0] cableIrq;
	logic        irqOut;
	logic [11:0] extOut;
	logic [31:0] rd;
	logic        er;
	int          nFail;
	int          compares;
	int          cyc;
	imru_row_s   rows [9] = '{
		'{8'h10, 32'hFFFFFFFF, 32'hFFF0FFFF, 1'b0},
		'{8'h14, 32'hFFFFFFFF, 32'h0F000F00, 1'b0},
		'{8'h34, 32'h00000F00, 32'h00000F00, 1'b0},
		'{8'h44, 32'hA5A5A5A5, 32'h05000500, 1'b0},
		'{8'h40, 32'hA5A5A5A5, 32'hA5A0A5A5, 1'b0},
		'{8'h64, 32'hFFFFFFFF, 32'h0F000F00, 1'b0},
		'{8'h78, 32'hFFFFFFFF, 32'h3F3F3F3F, 1'b0},
		'{8'h80, 32'hFFFFFFFF, 32'h00000000, 1'b1},
		'{8'h0C, 32'h12345678, 32'h00000000, 1'b1}};

	imru_top imru_top_inst (.clk(clk), .rst_n(rst_n), .ce(1'b1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .timerIrq(timerIrq),
		.extIrq(extIrq), .auxIrq(auxIrq), .cableIrq(cableIrq), .irqOut(irqOut),
		.extOut(extOut));

	imru_host imru_host_inst (.clk(clk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic ck(input string nm, input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			nFail++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		imru_host_inst.xfer(1'b1, a, d, rd, er);
	endtask

	task automatic rdck(input logic [7:0] a, input logic [31:0] exp);
		imru_host_inst.xfer(1'b0, a, 32'h00000000, rd, er);
		ck("readback", rd, exp);
	endtask

	task automatic conclude();
		if (nFail == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			nFail++;
			conclude();
		end
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		rst_n = 1'b0;
		timerIrq = 8'h00;
		extIrq = 12'hFFF;
		auxIrq = 4'h0;
		cableIrq = 12'h000;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		foreach (rows[i]) begin
			rdck(rows[i].addr, 32'h00000000);
			wr(rows[i].addr, rows[i].wdata);
			rdck(rows[i].addr, rows[i].rdExp);
			ck("error", {31'h0, er}, {31'h0, rows[i].errExp});
			wr(rows[i].addr, 32'h00000000);
		end
		wr(8'h10, 32'h00000000);
		// Soft request, enable gate, clear
		wr(8'h20, 32'h00000008);
		rdck(8'h20, 32'h00000008);
		ck("irq masked", {31'h0, irqOut}, 32'h0);
		wr(8'h24, 32'h00000100);
		rdck(8'h24, 32'h00000100);
		wr(8'h10, 32'h00000008);
		repeat (2) @(posedge clk);
		ck("irq on", {31'h0, irqOut}, 32'h1);
		wr(8'h30, 32'h00000008);
		wr(8'h34, 32'h00000100);
		rdck(8'h20, 32'h00000000);
		rdck(8'h24, 32'h00000000);
		ck("irq off", {31'h0, irqOut}, 32'h0);
		// Edge source, unarmed then armed
		wr(8'h60, 32'h00000001);
		for (int k = 0; k < 2; k++) begin
			wr(8'h40, k);
			timerIrq[0] <= 1'b1;
			repeat (4) @(posedge clk);
			timerIrq[0] <= 1'b0;
			repeat (6) @(posedge clk);
			rdck(8'h20, k);
		end
		wr(8'h30, 32'h00000001);
		// Level source, active low
		extIrq[0] <= 1'b0;
		wr(8'h50, 32'h00000100);
		repeat (6) @(posedge clk);
		rdck(8'h20, 32'h00000100);
		extIrq[0] <= 1'b1;
		repeat (6) @(posedge clk);
		wr(8'h30, 32'h00000100);
		rdck(8'h20, 32'h00000000);
		// Connector routing of timer 0 to output 0
		wr(8'h70, 32'h00000004);
		for (int k = 1; k >= 0; k--) begin
			timerIrq[0] <= k[0];
			repeat (6) @(posedge clk);
			ck("route", {31'h0, extOut[0]}, k);
		end
		// Auxiliary and cable sources on connector outputs 4 and 11
		wr(8'h74, 32'h00000020);
		wr(8'h78, 32'h18000000);
		auxIrq[0] <= 1'b1;
		cableIrq[8] <= 1'b1;
		repeat (6) @(posedge clk);
		ck("route aux", {31'h0, extOut[4]}, 32'h1);
		ck("route cable", {31'h0, extOut[11]}, 32'h1);
		// Cable 8 as an active-high level in the second bank
		wr(8'h64, 32'h01000000);
		wr(8'h54, 32'h01000000);
		rdck(8'h24, 32'h01000000);
		cableIrq[8] <= 1'b0;
		repeat (6) @(posedge clk);
		wr(8'h34, 32'h01000000);
		rdck(8'h24, 32'h00000000);
		// Reset in mid-run returns registers and outputs to zero
		wr(8'h20, 32'h00000001);
		wr(8'h10, 32'h00000001);
		repeat (2) @(posedge clk);
		ck("irq before reset", {31'h0, irqOut}, 32'h1);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		ck("irq after reset", {31'h0, irqOut}, 32'h0);
		ck("ext after reset", {20'h00000, extOut}, 32'h00000000);
		rdck(8'h20, 32'h00000000);
		rdck(8'h10, 32'h00000000);
		rdck(8'h78, 32'h00000000);
		conclude();
	end
endmodule

// [design/imru_defines.svh]
`ifndef IMRU_DEFINES_SVH
`define IMRU_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define IMRU_OFS_ENABLE_LO   8'h10
`define IMRU_OFS_ENABLE_HI   8'h14
`define IMRU_OFS_REQPEND_LO  8'h20
`define IMRU_OFS_REQPEND_HI  8'h24
`define IMRU_OFS_CLEAR_LO    8'h30
`define IMRU_OFS_CLEAR_HI    8'h34
`define IMRU_OFS_ARM_LO      8'h40
`define IMRU_OFS_ARM_HI      8'h44
`define IMRU_OFS_LEVEL_LO    8'h50
`define IMRU_OFS_LEVEL_HI    8'h54
`define IMRU_OFS_POL_LO      8'h60
`define IMRU_OFS_POL_HI      8'h64
`define IMRU_OFS_ROUTE_A     8'h70
`define IMRU_OFS_ROUTE_B     8'h74
`define IMRU_OFS_ROUTE_C     8'h78

// ----------------------------------------------------------------
// Field layout and reset values
// ----------------------------------------------------------------
`define IMRU_VALID_LO        32'hFFF0FFFF
`define IMRU_VALID_HI        32'h0F000F00
`define IMRU_VALID_ROUTE     32'h3F3F3F3F
`define IMRU_RESET_BANK      64'h0000000000000000
`define IMRU_RESET_WORD      32'h00000000
`define IMRU_CODE_W          6
`define IMRU_ROUTE_MAX       12

`endif

// [design/imru_pkg.sv]
package imru_pkg;

	typedef logic [63:0] imru_bank_t;

	typedef struct packed {
		imru_bank_t       sync1;
		imru_bank_t       sync2;
		imru_bank_t       prevAct;
		imru_bank_t       enable;
		imru_bank_t       pend;
		imru_bank_t       arm;
		imru_bank_t       level;
		imru_bank_t       pol;
		imru_bank_t       clr;
		logic [2:0][31:0] route;
		logic [31:0]      prdata;
		logic             pready;
		logic             pslverr;
		logic             irq;
		logic [11:0]      ext;
	} imru_state_s;

endpackage

// [design/imru_top.sv]
// How it works
// R01 - Stored one means on, zero off
// R02 - Enable bit gates source onto host interrupt
// R03 - Writing one to request raises soft request
// R04 - Pending shows latched, uncleared requests
// R05 - Writing one to clear drops pending
// R06 - Edge requests latch only while armed
// R07 - Level bit picks level, else edge
// R08 - Polarity bit picks high/rising or low/falling
// R09 - Banks sit at their fixed paired offsets
// R10 - Connector outputs follow their routing codes
// R11 - Request writes, pending reads share offsets
// R12 - Bank bits map timer, external, aux, cable
// R13 - Routing words hold four six-bit codes
//
// The implementer's own choice: register access over APB.
`include "imru_defines.svh"

module imru_top
	import imru_pkg::*;
#(
	parameter int ROUTE_OUTS = 12
) (
	input  wire logic                  clk,      // 40 MHz clock
	input  wire logic                  rst_n,    // Async reset
	input  wire logic                  ce,       // Clock enable
	input  wire logic                  psel,     // APB select
	input  wire logic                  penable,  // APB enable
	input  wire logic                  pwrite,   // APB direction
	input  wire logic [7:0]            paddr,    // APB byte address
	input  wire logic [31:0]           pwdata,   // APB write data
	output logic      [31:0]           prdata,   // APB read data
	output logic                       pready,   // APB ready
	output logic                       pslverr,  // APB error
	input  wire logic [7:0]            timerIrq, // Timer sources
	input  wire logic [11:0]           extIrq,   // External sources, edge or level
	input  wire logic [3:0]            auxIrq,   // Auxiliary sources
	input  wire logic [11:0]           cableIrq, // Cable sources
	output logic                       irqOut,   // Host interrupt
	output logic      [ROUTE_OUTS-1:0] extOut    // Connector outputs
);

	// ------------------------------------------------------------
	// Elaboration check
	// ------------------------------------------------------------
	if (ROUTE_OUTS < 1 || ROUTE_OUTS > `IMRU_ROUTE_MAX) begin : gChk
		$error("ROUTE_OUTS out of range");
	end

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	function automatic logic isMapped(input logic [7:0] a);
		logic hit;
		hit = 1'b0;
		if (a == `IMRU_OFS_ENABLE_LO || a == `IMRU_OFS_ENABLE_HI) begin
			hit = 1'b1;
		end else if (a == `IMRU_OFS_REQPEND_LO || a == `IMRU_OFS_REQPEND_HI) begin
			hit = 1'b1;
		end else if (a == `IMRU_OFS_CLEAR_LO || a == `IMRU_OFS_CLEAR_HI) begin
			hit = 1'b1;
		end else if (a == `IMRU_OFS_ARM_LO || a == `IMRU_OFS_ARM_HI) begin
			hit = 1'b1;
		end else if (a == `IMRU_OFS_LEVEL_LO || a == `IMRU_OFS_LEVEL_HI) begin
			hit = 1'b1;
		end else if (a == `IMRU_OFS_POL_LO || a == `IMRU_OFS_POL_HI) begin
			hit = 1'b1;
		end else if (a == `IMRU_OFS_ROUTE_A || a == `IMRU_OFS_ROUTE_B) begin
			hit = 1'b1;
		end else if (a == `IMRU_OFS_ROUTE_C) begin
			hit = 1'b1;
		end
		return hit;
	endfunction

	// Places a 32-bit word into one half of a 64-bit bank
	function automatic imru_bank_t toBank(input logic hi, input logic [31:0] w);
		imru_bank_t b;
		b = hi ? {w & `IMRU_VALID_HI, 32'h00000000} : {32'h00000000, w & `IMRU_VALID_LO};
		return b;
	endfunction

	imru_state_s s;
	imru_state_s nxt;

	imru_bank_t  srcRaw;
	imru_bank_t  validMask;
	imru_bank_t  active;
	imru_bank_t  edgeHit;
	imru_bank_t  lvlHit;
	imru_bank_t  swSet;
	imru_bank_t  clrVec;
	imru_bank_t  setVec;
	imru_bank_t  routeSrc;
	logic [11:0] routeSel;
	logic        acc;
	logic        wrFire;

	// ------------------------------------------------------------
	// Source layout in the banks
	// ------------------------------------------------------------
	assign srcRaw = {4'h0, cableIrq[11:8], 12'h000, extIrq[11:8], 8'h00,
		cableIrq[7:0], auxIrq, 4'h0, extIrq[7:0], timerIrq}; // R12
	assign validMask = {`IMRU_VALID_HI, `IMRU_VALID_LO}; // R12

	// ------------------------------------------------------------
	// Source qualification
	// ------------------------------------------------------------
	assign active  = ~(s.sync2 ^ s.pol) & validMask; // R08 R01
	assign edgeHit = active & ~s.prevAct & ~s.level & s.arm; // R06 R07
	assign lvlHit  = active & s.level; // R07

	// ------------------------------------------------------------
	// Bus strobes
	// ------------------------------------------------------------
	assign acc    = psel & penable & ~s.pready;
	assign wrFire = psel & penable & pwrite & s.pready;

	assign swSet = !wrFire ? `IMRU_RESET_BANK :
		(paddr == `IMRU_OFS_REQPEND_LO) ? toBank(1'b0, pwdata) :
		(paddr == `IMRU_OFS_REQPEND_HI) ? toBank(1'b1, pwdata) :
		`IMRU_RESET_BANK; // R03 R11
	assign clrVec = !wrFire ? `IMRU_RESET_BANK :
		(paddr == `IMRU_OFS_CLEAR_LO) ? toBank(1'b0, pwdata) :
		(paddr == `IMRU_OFS_CLEAR_HI) ? toBank(1'b1, pwdata) :
		`IMRU_RESET_BANK; // R05
	assign setVec = edgeHit | lvlHit | swSet;

	// ------------------------------------------------------------
	// Routing source table, indexed by six-bit code
	// ------------------------------------------------------------
	assign routeSrc = {4'h0, s.sync2[43:40], 12'h000, s.sync2[15:12],
		s.sync2[7:4], 3'h0, s.sync2[20], 4'h0, s.sync2[59:56], s.sync2[31:24],
		4'h0, s.sync2[11:8], s.sync2[3:0], 4'h0}; // R10

	for (genvar i = 0; i < `IMRU_ROUTE_MAX; i++) begin : gRoute
		assign routeSel[i] = routeSrc[s.route[i / 4][(i % 4) * 8 +: `IMRU_CODE_W]]; // R10 R13
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		nxt = s;
		if (ce) begin
			nxt.sync1   = srcRaw;
			nxt.sync2   = s.sync1;
			nxt.prevAct = active;
			nxt.pend    = (s.pend & ~clrVec) | setVec; // R04 R05
			nxt.irq     = |(s.pend & s.enable); // R02
			nxt.ext     = routeSel; // R10
			nxt.pready  = acc;
			nxt.pslverr = acc & ~isMapped(paddr);
			if (acc && !pwrite) begin
				if (paddr == `IMRU_OFS_ENABLE_LO) begin // R09
					nxt.prdata = s.enable[31:0];
				end else if (paddr == `IMRU_OFS_ENABLE_HI) begin
					nxt.prdata = s.enable[63:32];
				end else if (paddr == `IMRU_OFS_REQPEND_LO) begin // R11 R04
					nxt.prdata = s.pend[31:0];
				end else if (paddr == `IMRU_OFS_REQPEND_HI) begin
					nxt.prdata = s.pend[63:32];
				end else if (paddr == `IMRU_OFS_CLEAR_LO) begin
					nxt.prdata = s.clr[31:0];
				end else if (paddr == `IMRU_OFS_CLEAR_HI) begin
					nxt.prdata = s.clr[63:32];
				end else if (paddr == `IMRU_OFS_ARM_LO) begin
					nxt.prdata = s.arm[31:0];
				end else if (paddr == `IMRU_OFS_ARM_HI) begin
					nxt.prdata = s.arm[63:32];
				end else if (paddr == `IMRU_OFS_LEVEL_LO) begin
					nxt.prdata = s.level[31:0];
				end else if (paddr == `IMRU_OFS_LEVEL_HI) begin
					nxt.prdata = s.level[63:32];
				end else if (paddr == `IMRU_OFS_POL_LO) begin
					nxt.prdata = s.pol[31:0];
				end else if (paddr == `IMRU_OFS_POL_HI) begin
					nxt.prdata = s.pol[63:32];
				end else if (paddr == `IMRU_OFS_ROUTE_A) begin
					nxt.prdata = s.route[0];
				end else if (paddr == `IMRU_OFS_ROUTE_B) begin
					nxt.prdata = s.route[1];
				end else if (paddr == `IMRU_OFS_ROUTE_C) begin
					nxt.prdata = s.route[2];
				end else begin
					nxt.prdata = `IMRU_RESET_WORD;
				end
			end
			if (wrFire) begin
				if (paddr == `IMRU_OFS_ENABLE_LO) begin // R09 R01
					nxt.enable[31:0] = pwdata & `IMRU_VALID_LO;
				end else if (paddr == `IMRU_OFS_ENABLE_HI) begin
					nxt.enable[63:32] = pwdata & `IMRU_VALID_HI;
				end else if (paddr == `IMRU_OFS_CLEAR_LO) begin
					nxt.clr[31:0] = pwdata & `IMRU_VALID_LO;
				end else if (paddr == `IMRU_OFS_CLEAR_HI) begin
					nxt.clr[63:32] = pwdata & `IMRU_VALID_HI;
				end else if (paddr == `IMRU_OFS_ARM_LO) begin
					nxt.arm[31:0] = pwdata & `IMRU_VALID_LO;
				end else if (paddr == `IMRU_OFS_ARM_HI) begin
					nxt.arm[63:32] = pwdata & `IMRU_VALID_HI;
				end else if (paddr == `IMRU_OFS_LEVEL_LO) begin
					nxt.level[31:0] = pwdata & `IMRU_VALID_LO;
				end else if (paddr == `IMRU_OFS_LEVEL_HI) begin
					nxt.level[63:32] = pwdata & `IMRU_VALID_HI;
				end else if (paddr == `IMRU_OFS_POL_LO) begin
					nxt.pol[31:0] = pwdata & `IMRU_VALID_LO;
				end else if (paddr == `IMRU_OFS_POL_HI) begin
					nxt.pol[63:32] = pwdata & `IMRU_VALID_HI;
				end else if (paddr == `IMRU_OFS_ROUTE_A) begin // R13
					nxt.route[0] = pwdata & `IMRU_VALID_ROUTE;
				end else if (paddr == `IMRU_OFS_ROUTE_B) begin
					nxt.route[1] = pwdata & `IMRU_VALID_ROUTE;
				end else if (paddr == `IMRU_OFS_ROUTE_C) begin
					nxt.route[2] = pwdata & `IMRU_VALID_ROUTE;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= nxt;
		end
	end

	assign prdata  = s.prdata;
	assign pready  = s.pready;
	assign pslverr = s.pslverr;
	assign irqOut  = s.irq;
	assign extOut  = s.ext[ROUTE_OUTS-1:0];

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence sAccess;
		ce && psel && penable && !pready;
	endsequence

	sequence sReadPendLo;
		sAccess ##0 (!pwrite && paddr == `IMRU_OFS_REQPEND_LO);
	endsequence

	sequence sWriteReqLo;
		ce && wrFire && paddr == `IMRU_OFS_REQPEND_LO;
	endsequence

	a_apb_ready_next: assert property (sAccess |=> pready ##1 !pready) // R09
		else $error("pready not one cycle after access");

	a_pend_read: assert property (sReadPendLo |=> prdata == $past(s.pend[31:0])) // R04 R11
		else $error("pending read mismatch");

	a_soft_request: assert property (sWriteReqLo // R03
		|=> ((($past(pwdata) & `IMRU_VALID_LO) & ~s.pend[31:0]) == 32'h00000000))
		else $error("soft request not latched");

	a_clear_drop: assert property (ce && |clrVec // R05
		|=> ((s.pend & $past(clrVec) & ~$past(setVec)) == 64'h0))
		else $error("clear did not drop pending");

	a_clear_keep: assert property (ce // R05
		|=> (($past(s.pend) & ~$past(clrVec) & ~s.pend) == 64'h0))
		else $error("pending lost without clear");

	a_edge_unarmed: assert property (ce && |(active & ~s.level & ~s.arm & ~swSet) // R06
		|=> ((s.pend & ~$past(s.pend) & ~$past(s.level)
			& ~$past(s.arm) & ~$past(swSet)) == 64'h0))
		else $error("unarmed edge latched");

	a_level_sense: assert property (ce // R07 R08
		|=> (($past(lvlHit) & ~s.pend) == 64'h0))
		else $error("active level not pending");

	a_irq_gate: assert property ($past(ce) // R02
		|-> irqOut == |($past(s.pend) & $past(s.enable)))
		else $error("interrupt output wrong");

	a_route_out: assert property (ce |=> extOut == $past(routeSel[ROUTE_OUTS-1:0])) // R10
		else $error("connector output wrong");

	a_reserved_zero: assert property (((s.enable & ~validMask) == 64'h0) // R12 R13
		&& (((s.arm | s.level | s.pol | s.clr | s.pend) & ~validMask) == 64'h0)
		&& (((s.route[0] | s.route[1] | s.route[2]) & ~`IMRU_VALID_ROUTE) == 32'h00000000))
		else $error("reserved bits set");

	// ------------------------------------------------------------
	// Further checks on bus answers and sensing
	// ------------------------------------------------------------
	sequence sReadUnmapped;
		sAccess ##0 (!pwrite && !isMapped(paddr));
	endsequence

	sequence sMappedAccess;
		sAccess ##0 isMapped(paddr);
	endsequence

	sequence sWriteReqHi;
		ce && wrFire && paddr == `IMRU_OFS_REQPEND_HI;
	endsequence

	sequence sWriteEnableLo;
		ce && wrFire && paddr == `IMRU_OFS_ENABLE_LO;
	endsequence

	a_error_unmapped: assert property (sReadUnmapped // R09
		|=> pslverr && prdata == 32'h00000000)
		else $error("unmapped read not refused");

	a_error_mapped: assert property (sMappedAccess |=> !pslverr) // R09
		else $error("mapped address flagged");

	a_ready_idle: assert property (ce && !psel |=> !pready) // R09
		else $error("pready without access");

	a_soft_request_hi: assert property (sWriteReqHi // R03 R11
		|=> ((($past(pwdata) & `IMRU_VALID_HI) & ~s.pend[63:32]) == 32'h00000000))
		else $error("high soft request not latched");

	a_enable_store: assert property (sWriteEnableLo // R02 R09
		|=> s.enable[31:0] == ($past(pwdata) & `IMRU_VALID_LO))
		else $error("enable write lost");

	a_edge_armed: assert property (ce && |edgeHit // R06
		|=> (($past(edgeHit) & ~s.pend) == 64'h0))
		else $error("armed edge not latched");

	a_level_high: assert property (ce // R08
		|=> (($past(s.level) & $past(s.pol) & $past(s.sync2)
			& validMask & ~s.pend) == 64'h0))
		else $error("active-high level not pending");

	a_level_low: assert property (ce // R08
		|=> (($past(s.level) & ~$past(s.pol) & ~$past(s.sync2)
			& validMask & ~s.pend) == 64'h0))
		else $error("active-low level not pending");

endmodule
